// [src/errrec_pkg.sv]
// constants, codes and carrier types for the error record counter registers
package errrec_pkg;

   // ------------------------------------------------------------------
   // feature register field positions and codes
   // ------------------------------------------------------------------
   localparam int FR_LOG_LSB    = 0;
   localparam int FR_IMPL_LSB   = 2;
   localparam int FR_REC_LSB    = 4;
   localparam int FR_FAULT_LSB  = 6;
   localparam int FR_ABORT_LSB  = 8;
   localparam int FR_CEC_LSB    = 12;
   localparam int FR_RP_BIT     = 15;

   localparam logic [1:0] SUP_NONE   = 2'h0;
   localparam logic [1:0] SUP_ALWAYS = 2'h1;
   localparam logic [1:0] SUP_ONE    = 2'h2;
   localparam logic [1:0] SUP_SPLIT  = 2'h3;

   localparam logic [2:0] CEC_NONE   = 3'h0;
   localparam logic [2:0] CEC_NARROW = 3'h2;
   localparam logic [2:0] CEC_WIDE   = 3'h4;

   // ------------------------------------------------------------------
   // syndrome register layout
   // ------------------------------------------------------------------
   localparam int CNT_LSB         = 32;
   localparam int WIDE_CNT_W      = 15;
   localparam int NARROW_CNT_W    = 7;
   localparam int WIDE_FLAG_BIT   = 47;
   localparam int NARROW_FLAG_BIT = 39;
   localparam int OTHER_LSB       = 48;
   localparam int OTHER_FLAG_BIT  = 63;
   localparam int TAG_LSB         = 0;
   localparam int TAG_W           = 16;
   localparam int TAG_VALID_BIT   = 16;
   localparam int PEND_BIT        = 17;

   localparam logic [63:0] MASK_WIDE_SINGLE = 64'h0000_ffff_0000_0000;
   localparam logic [63:0] MASK_WIDE_REPEAT = 64'hffff_ffff_0000_0000;
   localparam logic [63:0] MASK_NARROW      = 64'h0000_00ff_0000_0000;
   localparam logic [63:0] MISC_RST         = 64'h0000_0000_0000_0000;
   localparam logic [63:0] RDATA_RST        = 64'h0000_0000_0000_0000;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      PART_FULL = 3'b001,
      PART_LOW  = 3'b010,
      PART_HIGH = 3'b100
   } part_type;

   typedef struct packed {
      logic             valid;
      logic             write;
      part_type         part;
      logic [7:0]       record;
      logic [63:0]      wdata;
   } acc_req_type;

   typedef struct packed {
      logic             ce;
      logic             de;
      logic             ue;
      logic             de_local;
      logic [TAG_W-1:0] syndrome;
   } err_event_type;

   typedef struct packed {
      logic [63:0]      misc;
      logic [63:0]      rdata;
      logic             rvalid;
      logic             abort;
   } state_type;

endpackage

// [src/error_record_counter_regs.sv]
// error record feature and miscellaneous syndrome registers with error counters
//
// How it works
// (RULE1) feature [9:8] reports in-band abort support with the four-value code.
// (RULE2) feature [7:6] reports fault interrupt support, same four-value code.
// (RULE3) feature [5:4] reports recovery interrupt support, same four-value code.
// (RULE4) feature [1:0] reads 01 for always-on logging or 10 for switchable.
// (RULE5) feature [3:2] returns a fixed value chosen at build time.
// (RULE6) build option decides whether locally held deferred errors still abort.
// (RULE7) with no counter code every syndrome bit is plain storage; here recovery reset still clears bits 16 and 17.
// (RULE8) a record that cannot count reads counters as zero, drops writes.
// (RULE9) writing zero to the low syndrome half quiesces and drops the interrupt.
// (RULE10) interrupt source is off after cold reset until control enable is set.
// (RULE11) wide single layout: count at [46:32], sticky wrap flag at 47.
// (RULE12) narrow single layout: count at [38:32], sticky wrap flag at 39.
// (RULE13) single counter counts every corrected error, deferred ones optionally.
// (RULE14) single wrap flag sets and holds when the counter wraps through zero.
// (RULE15) writing wrap flags may disturb the status overflow bit, and back.
// (RULE16) counters and flags survive error recovery reset.
// (RULE17) repeat layout: other flag 63, other count [62:48], repeat flag 47.
// (RULE18) repeat count counts first error, capturing its tag, then matching ones.
// (RULE19) other count counts every countable error that repeat count did not.
// (RULE20) other wrap flag sets and holds when the other count wraps.
// (RULE21) repeat wrap flag sets and holds when the repeat count wraps.
// (RULE22) 64-bit register reached whole or as halves when select matches.
// (RULE23) only the node's first record shows the feature value.
// (RULE24) layout parameters drive both counters and feature fields.
`timescale 1ns/100ps

module error_record_counter_regs
   import errrec_pkg::*;
#(
   parameter logic [2:0] CEC_CODE       = CEC_WIDE,
   parameter bit         REPEAT_PRESENT = 1'b0,
   parameter bit         CAN_COUNT      = 1'b1,
   parameter bit         COUNT_DEFERRED = 1'b0,
   parameter bit         DEFERRED_ABORT = 1'b0,
   parameter bit         FIRST_RECORD   = 1'b1,
   parameter logic [7:0] RECORD_NUM     = 8'h00,
   parameter logic [1:0] ABORT_CODE     = SUP_ALWAYS,
   parameter logic [1:0] FAULT_CODE     = SUP_ONE,
   parameter logic [1:0] RECOVERY_CODE  = SUP_ONE,
   parameter logic [1:0] LOG_CODE       = SUP_ALWAYS,
   parameter logic [1:0] IMPL_BITS      = 2'h0
) (
   input  logic          clk,            // 10 MHz clock
   input  logic          rstn,           // cold reset, async, active low
   input  logic          ce_en,          // clock enable, low freezes all state
   input  logic          erec_rst,       // error recovery reset, one cycle
   input  logic          ctl_irq_enable, // enable field from record control
   input  acc_req_type   acc,            // selected-record alias access
   input  err_event_type ev,             // error events from the node
   output logic [63:0]   rdata,          // read answer
   output logic          rvalid,         // read answer strobe
   output logic [63:0]   feature_reg,    // node feature register value
   output logic          fault_irq_req,  // fault handling interrupt request
   output logic          abort_resp      // in-band abort to the requester
);

   // ------------------------------------------------------------------
   // build-time layout
   // ------------------------------------------------------------------
   localparam bit          WIDE    = (CEC_CODE == CEC_WIDE);
   localparam bit          HAS_CEC = (CEC_CODE != CEC_NONE);
   // repeat layout only exists in wide form here
   localparam bit          REP     = REPEAT_PRESENT && WIDE;
   localparam bit          COUNTS  = CAN_COUNT && HAS_CEC;
   localparam bit          SINGLE  = COUNTS && !REP;
   localparam logic [63:0] CNT_MASK = !HAS_CEC ? 64'h0 :
                                      (REP ? MASK_WIDE_REPEAT :
                                      (WIDE ? MASK_WIDE_SINGLE : MASK_NARROW));
   localparam logic [14:0] PRIM_MAX = WIDE ? 15'h7fff : 15'h007f;
   localparam int          PRIM_FLAG = WIDE ? WIDE_FLAG_BIT : NARROW_FLAG_BIT;

   localparam logic [63:0] FEATURE_VAL = {
      48'h0,
      REP && HAS_CEC,                                       // RULE24
      CEC_CODE,                                             // RULE24
      2'h0,
      ABORT_CODE,                                           // RULE1
      FAULT_CODE,                                           // RULE2
      RECOVERY_CODE,                                        // RULE3
      IMPL_BITS,                                            // RULE5
      LOG_CODE                                              // RULE4
   };

   localparam state_type RST = '{misc: MISC_RST, rdata: RDATA_RST, rvalid: 1'b0,
                                 abort: 1'b0};

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // returns {wrap, value+1}; narrow counts pass {8'hff, v} so wrap tracks 7 bits
   function automatic logic [15:0] bump(input logic [14:0] v);
      return {&v, v + 15'h1};
   endfunction

   state_type   s_r;
   state_type   s_nxt;
   logic        hit;
   logic        countable;
   logic [63:0] wr_val;
   logic [15:0] b;

   assign hit       = acc.valid && (acc.record == RECORD_NUM);         // RULE22
   assign countable = ev.ce || (COUNT_DEFERRED && (ev.de || ev.ue));   // RULE13

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt        = s_r;
      wr_val       = s_r.misc;
      b            = 16'h0;
      s_nxt.rvalid = 1'b0;
      if (hit && acc.write) begin
         case (acc.part)                                            // RULE22
            PART_FULL: wr_val = acc.wdata;
            PART_LOW:  wr_val[31:0] = acc.wdata[31:0];
            PART_HIGH: wr_val[63:32] = acc.wdata[31:0];
            default:   wr_val = s_r.misc;
         endcase
      end
      // a record that cannot count keeps its counter fields at zero
      if (!CAN_COUNT) begin
         wr_val = wr_val & ~CNT_MASK;                               // RULE8
      end
      // counters and flags are left alone by error recovery reset
      if (erec_rst) begin
         wr_val[TAG_VALID_BIT] = 1'b0;                              // RULE16
         wr_val[PEND_BIT]      = 1'b0;
      end
      // events apply after the write, so a set beats a same-cycle clear
      if (COUNTS && countable) begin
         if (SINGLE && WIDE) begin
            b = bump(wr_val[CNT_LSB +: WIDE_CNT_W]);                // RULE13
            wr_val[CNT_LSB +: WIDE_CNT_W] = b[14:0];                // RULE11
            if (b[15]) begin
               wr_val[WIDE_FLAG_BIT] = 1'b1;                        // RULE14
               wr_val[PEND_BIT]      = 1'b1;
            end
         end else if (SINGLE) begin
            b = bump({8'hff, wr_val[CNT_LSB +: NARROW_CNT_W]});     // RULE13
            wr_val[CNT_LSB +: NARROW_CNT_W] = b[6:0];               // RULE12
            if (b[15]) begin
               wr_val[NARROW_FLAG_BIT] = 1'b1;                      // RULE14
               wr_val[PEND_BIT]        = 1'b1;
            end
         end else if (!wr_val[TAG_VALID_BIT] ||
                      wr_val[TAG_LSB +: TAG_W] == ev.syndrome) begin
            wr_val[TAG_LSB +: TAG_W] = ev.syndrome;                 // RULE18
            wr_val[TAG_VALID_BIT]    = 1'b1;
            b = bump(wr_val[CNT_LSB +: WIDE_CNT_W]);
            wr_val[CNT_LSB +: WIDE_CNT_W] = b[14:0];                // RULE18
            if (b[15]) begin
               wr_val[WIDE_FLAG_BIT] = 1'b1;                        // RULE21
               wr_val[PEND_BIT]      = 1'b1;
            end
         end else begin
            b = bump(wr_val[OTHER_LSB +: WIDE_CNT_W]);              // RULE19
            wr_val[OTHER_LSB +: WIDE_CNT_W] = b[14:0];              // RULE17
            if (b[15]) begin
               wr_val[OTHER_FLAG_BIT] = 1'b1;                       // RULE20
               wr_val[PEND_BIT]       = 1'b1;
            end
         end
      end
      s_nxt.misc = wr_val;                                          // RULE7
      if (hit && !acc.write) begin
         s_nxt.rvalid = 1'b1;
         case (acc.part)                                            // RULE22
            PART_LOW:  s_nxt.rdata = {32'h0, s_r.misc[31:0]};
            PART_HIGH: s_nxt.rdata = {32'h0, s_r.misc[63:32]};
            default:   s_nxt.rdata = s_r.misc;
         endcase
      end
      s_nxt.abort = (ABORT_CODE != SUP_NONE) &&
                    (ev.ue || (ev.de_local && DEFERRED_ABORT));     // RULE6
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // counters clear on cold reset: zero is one legal unknown value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= RST;                                                // RULE16
      end else if (ce_en) begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign rdata         = s_r.rdata;
   assign rvalid        = s_r.rvalid;
   assign abort_resp    = s_r.abort;
   assign feature_reg   = FIRST_RECORD ? FEATURE_VAL : 64'h0;      // RULE23
   // pending source stays silent until control software enables it
   assign fault_irq_req = s_r.misc[PEND_BIT] && ctl_irq_enable;    // RULE10

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   logic [14:0] prim_cnt;
   logic [14:0] other_cnt;
   logic        prim_flag;
   logic        quiet;

   assign prim_cnt  = WIDE ? s_r.misc[CNT_LSB +: WIDE_CNT_W]
                           : {8'h0, s_r.misc[CNT_LSB +: NARROW_CNT_W]};
   assign other_cnt = s_r.misc[OTHER_LSB +: WIDE_CNT_W];
   assign prim_flag = s_r.misc[PRIM_FLAG];
   assign quiet     = ce_en && !(hit && acc.write) && !erec_rst;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_feature_map: assert property (                                 // RULE1
      feature_reg == (FIRST_RECORD ? FEATURE_VAL : 64'h0) &&
      (!FIRST_RECORD || feature_reg[FR_LOG_LSB +: 2] == LOG_CODE))
      else $error("feature value differs from build settings");

   a_single_inc: assert property (                                  // RULE13
      SINGLE && quiet && countable |=>
      prim_cnt == (($past(prim_cnt) + 15'h1) & PRIM_MAX))
      else $error("single counter did not advance by one");

   a_single_wrap: assert property (                                 // RULE14
      SINGLE && quiet && countable && prim_cnt == PRIM_MAX |=>
      prim_cnt == 15'h0 && prim_flag ##1 (prim_flag || $past(hit && acc.write)))
      else $error("wrap flag not set or not held after wrap");

   a_repeat_first: assert property (                                // RULE18
      REP && COUNTS && quiet && countable && !s_r.misc[TAG_VALID_BIT] |=>
      s_r.misc[TAG_VALID_BIT] && s_r.misc[TAG_LSB +: TAG_W] == $past(ev.syndrome)
      && prim_cnt == $past(prim_cnt) + 15'h1)
      else $error("first countable error not captured by repeat count");

   a_other_inc: assert property (                                   // RULE19
      REP && COUNTS && quiet && countable && s_r.misc[TAG_VALID_BIT] &&
      s_r.misc[TAG_LSB +: TAG_W] != ev.syndrome |=>
      other_cnt == $past(other_cnt) + 15'h1 && $stable(prim_cnt))
      else $error("mismatching error not counted as other");

   a_other_wrap: assert property (                                  // RULE20
      REP && COUNTS && quiet && countable && s_r.misc[TAG_VALID_BIT] &&
      s_r.misc[TAG_LSB +: TAG_W] != ev.syndrome && other_cnt == 15'h7fff |=>
      s_r.misc[OTHER_FLAG_BIT] && other_cnt == 15'h0)
      else $error("other wrap flag not set on wrap");

   a_repeat_wrap: assert property (                                 // RULE21
      REP && COUNTS && quiet && countable && s_r.misc[TAG_VALID_BIT] &&
      s_r.misc[TAG_LSB +: TAG_W] == ev.syndrome && prim_cnt == 15'h7fff |=>
      s_r.misc[WIDE_FLAG_BIT] && prim_cnt == 15'h0)
      else $error("repeat wrap flag not set on wrap");

   a_zero_quiet: assert property (                                  // RULE9
      ce_en && hit && acc.write && acc.part == PART_LOW &&
      acc.wdata[31:0] == 32'h0 && !(COUNTS && countable) |=>
      !fault_irq_req && s_r.misc[31:0] == 32'h0)
      else $error("zero write left the record active");

   a_irq_gate: assert property (                                    // RULE10
      !ctl_irq_enable |-> !fault_irq_req)
      else $error("interrupt raised while disabled");

   a_nocount_zero: assert property (                                // RULE8
      !CAN_COUNT |-> (s_r.misc & CNT_MASK) == 64'h0)
      else $error("counter fields of non-counting record not zero");

   a_recovery_keep: assert property (                               // RULE16
      ce_en && erec_rst && !(hit && acc.write) && !countable |=>
      $stable(s_r.misc[63:32]) && !s_r.misc[PEND_BIT])
      else $error("recovery reset disturbed counters");

   a_read_answer: assert property (                                 // RULE22
      ce_en && hit && !acc.write && acc.part == PART_HIGH |=>
      rvalid && rdata == {32'h0, $past(s_r.misc[63:32])} ##1 !rvalid || $past(hit))
      else $error("high half read answered wrongly");

endmodule // error_record_counter_regs

// [verif/tb_top.sv]
// self-checking testbench for the error record counter registers
`timescale 1ns/100ps

module tb_top;
   import errrec_pkg::*;

   localparam logic [7:0] REC = 8'h03;

   logic          clk;
   logic          rstn;
   logic          ce_en;
   logic          erec_rst;
   logic          ctl_irq_enable;
   acc_req_type   acc;
   err_event_type ev;
   logic [63:0]   rdata;
   logic          rvalid;
   logic [63:0]   feature_reg;
   logic          fault_irq_req;
   logic          abort_resp;
   logic [63:0]   rdata_s;
   logic          fault_irq_s;
   int            n_errors;
   int            samples_checked;

   error_record_counter_regs #(
      .CEC_CODE       (CEC_WIDE),
      .REPEAT_PRESENT (1'b1),
      .RECORD_NUM     (REC),
      .ABORT_CODE     (SUP_SPLIT),
      .FAULT_CODE     (SUP_ONE),
      .RECOVERY_CODE  (SUP_SPLIT),
      .LOG_CODE       (SUP_ONE),
      .IMPL_BITS      (2'h1)
   ) error_record_counter_regs_inst (
      .clk            (clk),
      .rstn           (rstn),
      .ce_en          (ce_en),
      .erec_rst       (erec_rst),
      .ctl_irq_enable (ctl_irq_enable),
      .acc            (acc),
      .ev             (ev),
      .rdata          (rdata),
      .rvalid         (rvalid),
      .feature_reg    (feature_reg),
      .fault_irq_req  (fault_irq_req),
      .abort_resp     (abort_resp)
   );

   // second copy in the wide single layout so its counter checks come alive
   error_record_counter_regs #(
      .RECORD_NUM     (REC)
   ) error_record_counter_regs_single_inst (
      .clk            (clk),
      .rstn           (rstn),
      .ce_en          (ce_en),
      .erec_rst       (erec_rst),
      .ctl_irq_enable (ctl_irq_enable),
      .acc            (acc),
      .ev             (ev),
      .rdata          (rdata_s),
      .rvalid         (),
      .feature_reg    (),
      .fault_irq_req  (fault_irq_s),
      .abort_resp     ()
   );

   // ------------------------------------------------------------------
   // clock and helpers
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input part_type p, input logic [7:0] r, input logic [63:0] d);
      @(posedge clk);
      acc <= '{valid: 1'b1, write: 1'b1, part: p, record: r, wdata: d};
      @(posedge clk);
      acc <= '0;
      #1;
   endtask

   task automatic rd(input part_type p, input logic [63:0] exp);
      @(posedge clk);
      acc <= '{valid: 1'b1, write: 1'b0, part: p, record: REC, wdata: 64'h0};
      @(posedge clk);
      acc <= '0;
      #1;
      chk("rvalid", 64'h1, {63'h0, rvalid});
      chk("rdata", exp, rdata);
   endtask

   // one error event; abort answer is looked at in the cycle after it stands
   task automatic evt(input logic c, input logic u, input logic dl, input logic [15:0] s,
                      input logic ab);
      @(posedge clk);
      ev <= '{ce: c, de: 1'b0, ue: u, de_local: dl, syndrome: s};
      @(posedge clk);
      ev <= '0;
      #1;
      chk("abort_resp", {63'h0, ab}, {63'h0, abort_resp});
   endtask

   task automatic irq(input logic exp);
      chk("fault_irq_req", {63'h0, exp}, {63'h0, fault_irq_req});
   endtask

   // ------------------------------------------------------------------
   // watchdog: whole sequence needs well under 1000 cycles
   // ------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      n_errors = 0;
      samples_checked = 0;
      rstn = 1'b0;
      ce_en = 1'b1;
      erec_rst = 1'b0;
      ctl_irq_enable = 1'b0;
      acc = '0;
      ev = '0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("feature_reg", {48'h0, 1'b1, CEC_WIDE, 2'h0, SUP_SPLIT, SUP_ONE, SUP_SPLIT, 2'h1,
          SUP_ONE}, feature_reg);
      irq(1'b0);
      rd(PART_FULL, 64'h0);
      // whole and half accesses, other record ignored
      wr(PART_FULL, REC, 64'h0123_4567_5550_1234);
      rd(PART_LOW, 64'h0000_0000_5550_1234);
      rd(PART_HIGH, 64'h0000_0000_0123_4567);
      wr(PART_HIGH, REC, 64'h0000_0000_89ab_cdef);
      rd(PART_FULL, 64'h89ab_cdef_5550_1234);
      wr(PART_FULL, 8'h05, 64'h0);
      rd(PART_FULL, 64'h89ab_cdef_5550_1234);
      // repeat and other counting
      wr(PART_FULL, REC, 64'h0);
      evt(1'b1, 1'b0, 1'b0, 16'h1234, 1'b0);
      rd(PART_FULL, 64'h0000_0001_0001_1234);
      evt(1'b1, 1'b0, 1'b0, 16'h1234, 1'b0);
      evt(1'b1, 1'b0, 1'b0, 16'h0bad, 1'b0);
      rd(PART_FULL, 64'h0001_0002_0001_1234);
      // abort answers; uncorrected not counted, deferred local does not abort
      evt(1'b0, 1'b1, 1'b0, 16'h1234, 1'b1);
      evt(1'b0, 1'b0, 1'b1, 16'h1234, 1'b0);
      rd(PART_FULL, 64'h0001_0002_0001_1234);
      // wraps, sticky flags, interrupt gating
      wr(PART_FULL, REC, 64'h7fff_7fff_0001_abcd);
      evt(1'b1, 1'b0, 1'b0, 16'habcd, 1'b0);
      rd(PART_FULL, 64'h7fff_8000_0003_abcd);
      irq(1'b0);
      @(posedge clk);
      ctl_irq_enable <= 1'b1;
      #1;
      irq(1'b1);
      evt(1'b1, 1'b0, 1'b0, 16'h1111, 1'b0);
      rd(PART_FULL, 64'h8000_8000_0003_abcd);
      evt(1'b1, 1'b0, 1'b0, 16'habcd, 1'b0);
      rd(PART_FULL, 64'h8000_8001_0003_abcd);
      // zero to the low half quiesces and withdraws the request
      wr(PART_LOW, REC, 64'h0);
      irq(1'b0);
      rd(PART_FULL, 64'h8000_8001_0000_0000);
      // recovery reset keeps counters and flags
      evt(1'b1, 1'b0, 1'b0, 16'h2222, 1'b0);
      rd(PART_FULL, 64'h8000_8002_0001_2222);
      @(posedge clk);
      erec_rst <= 1'b1;
      @(posedge clk);
      erec_rst <= 1'b0;
      rd(PART_FULL, 64'h8000_8002_0000_2222);
      // frozen clock enable drops the event
      @(posedge clk);
      ce_en <= 1'b0;
      evt(1'b1, 1'b1, 1'b0, 16'h2222, 1'b0);
      @(posedge clk);
      ce_en <= 1'b1;
      rd(PART_FULL, 64'h8000_8002_0000_2222);
      // wrap in both layouts from one event
      wr(PART_FULL, REC, 64'h0000_7fff_0000_0000);
      evt(1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
      rd(PART_FULL, 64'h0000_8000_0003_0000);
      chk("rdata_single", 64'h0000_8000_0002_0000, rdata_s);
      chk("fault_irq_single", 64'h1, {63'h0, fault_irq_s});
      report_and_stop();
   end

endmodule // tb_top
